// file: asr_pkg.sv
// Package with register map, field positions and types for the serial receive error block.
package asr_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam logic [3:0]  ADDR_MODE       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h1;
  localparam logic [3:0]  ADDR_DATA       = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h3;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h4;
  localparam logic [3:0]  ADDR_CTRL       = 4'h5;
  localparam int          RATIO_SEL_BIT   = 3;
  localparam logic [7:0]  MODE_RSVD_VAL   = 8'h00;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam int          ST_FULL         = 0;
  localparam int          ST_OVR          = 1;
  localparam int          ST_FRM          = 2;
  localparam int          ST_PAR          = 3;
  localparam int          CTRL_EN         = 0;
  localparam int          CTRL_ASYNC      = 1;
  localparam int          CTRL_PAREN      = 2;
  localparam int          CTRL_PARODD     = 3;
  localparam int          OVS_16          = 16;
  localparam int          OVS_8           = 8;
  localparam int          FRAME_DATA_BITS = 8;
  localparam int          CLK_HZ          = 20_000_000;

  // One received frame with its error indications.
  typedef struct packed {
    logic [7:0] data;
    logic       frm_err;
    logic       par_err;
  } asr_frame_t;

  // Register bus request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } asr_bus_t;
endpackage : asr_pkg

// file: asr_baud.sv
// Basic-clock tick generator at 16x or 8x the bit rate.
`timescale 1ns/100ps
module asr_baud
  import asr_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [DIV_W-1:0] i_div,
  output logic                  o_tick
);
  logic [DIV_W-1:0] cnt_q;

  // Tick once every i_div+1 system clocks; a zero divisor ticks every cycle.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (cnt_q >= i_div) begin
      cnt_q  <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule : asr_baud

// file: asr_rxcore.sv
// Serial frame sampler: start detect, mid-bit sampling, parity and stop check.
`timescale 1ns/100ps
module asr_rxcore
  import asr_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_tick,
  input  wire logic i_ovs8,
  input  wire logic i_enable,
  input  wire logic i_par_en,
  input  wire logic i_par_odd,
  input  wire logic i_rxd,
  output logic      o_done,
  output asr_frame_t o_frame
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} asr_rx_state_t;
  asr_rx_state_t state_q;
  logic [4:0]    sub_q;
  logic [3:0]    bit_q;
  logic [8:0]    shift_q;
  logic          rxd_q;
  logic [4:0]    ovs;
  logic [4:0]    half;
  logic [3:0]    nbits;

  assign ovs   = i_ovs8 ? 5'(OVS_8) : 5'(OVS_16);
  assign half  = ovs >> 1;
  assign nbits = i_par_en ? 4'(FRAME_DATA_BITS + 1) : 4'(FRAME_DATA_BITS);

  // Previous line level for falling-edge detection.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) rxd_q <= 1'b1;
    else           rxd_q <= i_rxd;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= RX_IDLE;
      sub_q   <= '0;
      bit_q   <= '0;
      shift_q <= '0;
      o_done  <= 1'b0;
      o_frame <= '0;
    end else begin
      o_done <= 1'b0;
      case (state_q)
        RX_IDLE: begin
          if (i_enable && rxd_q && !i_rxd) begin
            state_q <= RX_START;
            sub_q   <= '0;
          end
        end
        RX_START: begin
          if (i_tick) begin
            if (sub_q == half - 5'd1) begin
              // A start bit gone high at mid-bit was a glitch.
              state_q <= i_rxd ? RX_IDLE : RX_BITS;
              sub_q   <= '0;
              bit_q   <= '0;
            end else begin
              sub_q <= sub_q + 5'd1;
            end
          end
        end
        RX_BITS: begin
          if (i_tick) begin
            if (sub_q == ovs - 5'd1) begin
              sub_q   <= '0;
              shift_q <= {i_rxd, shift_q[8:1]};
              bit_q   <= bit_q + 4'd1;
              if (bit_q == nbits - 4'd1) state_q <= RX_STOP;
            end else begin
              sub_q <= sub_q + 5'd1;
            end
          end
        end
        RX_STOP: begin
          if (i_tick) begin
            if (sub_q == ovs - 5'd1) begin
              state_q         <= RX_IDLE;
              sub_q           <= '0;
              o_done          <= 1'b1;
              o_frame.frm_err <= !i_rxd;
              o_frame.data    <= i_par_en ? shift_q[7:0] : shift_q[8:1];
              o_frame.par_err <= i_par_en && ((^shift_q) ^ i_par_odd);
            end else begin
              sub_q <= sub_q + 5'd1;
            end
          end
        end
        default: state_q <= RX_IDLE;
      endcase
    end
  end
endmodule : asr_rxcore

// file: asr_top.sv
// Asynchronous serial receiver with error flags, register port and interrupt.
// Notes on behaviour
// - The basic clock is 16 times the bit rate when the select bit is 0 and 8 times when it is 1.
// - The select bit sits at bit 3 of the mode register, is read/write, resets to 0 and acts only in async mode.
// - A frame with any receive error leaves the receive-full flag as it was.
// - No frame is received while the overrun, framing or parity flag is set.
// - An overrun sets the overrun flag and drops the frame's data, whatever other errors it has.
// - Framing or parity errors alone set their flags, leave overrun clear and still store the byte.
// - Overrun with parity error sets both flags, leaves framing clear and drops the data.
// - Bits 7 to 4 of the mode register are reserved, read as a fixed value and cannot be written.
`timescale 1ns/100ps
module asr_top
  import asr_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  input  wire logic [DIV_W-1:0] i_div,
  input  wire logic             i_rxd,
  output logic [DATA_W-1:0]     o_rdata,
  output logic                  o_irq
);
  asr_bus_t   bus;
  asr_frame_t frame;
  logic [3:0] mode_low_q;
  logic [3:0] ctrl_q;
  logic [7:0] rx_data_q;
  logic       full_q;
  logic       ovr_q;
  logic       frm_q;
  logic       par_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic       tick;
  logic       done;
  logic       err_any;
  logic       ovs8;
  logic       rx_enable;
  logic       wr_status;
  logic [3:0] ev;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // Byte-wide write decode helper.
  function automatic logic hit(input asr_bus_t b, input logic [3:0] a);
    return b.wr && (b.addr == a);
  endfunction : hit

  // ratio select honoured only in async mode.
  assign ovs8 = ctrl_q[CTRL_ASYNC] && mode_low_q[RATIO_SEL_BIT];
  assign err_any = ovr_q || frm_q || par_q;
  assign rx_enable = ctrl_q[CTRL_EN] && ctrl_q[CTRL_ASYNC] && !err_any;
  assign wr_status = hit(bus, ADDR_STATUS);

  asr_baud #(.DIV_W(DIV_W)) u_baud (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_div    (i_div),
    .o_tick   (tick)
  );

  asr_rxcore u_rx (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_tick    (tick),
    .i_ovs8    (ovs8),
    .i_enable  (rx_enable),
    .i_par_en  (ctrl_q[CTRL_PAREN]),
    .i_par_odd (ctrl_q[CTRL_PARODD]),
    .i_rxd     (i_rxd),
    .o_done    (done),
    .o_frame   (frame)
  );

  // only the low nibble of the mode register is stored.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)                 mode_low_q <= MODE_RESET[3:0];
    else if (hit(bus, ADDR_MODE))  mode_low_q <= bus.wdata[3:0];
  end

  // Control bits: enable, async mode, parity enable, odd parity.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)                 ctrl_q <= '0;
    else if (hit(bus, ADDR_CTRL))  ctrl_q <= bus.wdata[3:0];
  end

  // byte stored on framing or parity error alone.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)             rx_data_q <= '0;
    else if (done && !full_q)  rx_data_q <= frame.data;
  end

  // Receive-full flag: set by a clean frame, cleared by writing 0, set wins.
  // full flag kept on error.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      full_q <= 1'b0;
    end else if (done && !full_q && !frame.frm_err && !frame.par_err) begin
      full_q <= 1'b1;
    end else if (wr_status && !bus.wdata[ST_FULL]) begin
      full_q <= 1'b0;
    end
  end

  // Error flags are cleared by writing 0, so writing back a read value also clears a flag that rose after the read; set wins.
  // overrun and parity flagged together, framing from the frame only.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovr_q <= 1'b0;
      frm_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      ovr_q <= (done && full_q) || (ovr_q && !(wr_status && !bus.wdata[ST_OVR]));
      frm_q <= (done && frame.frm_err) || (frm_q && !(wr_status && !bus.wdata[ST_FRM]));
      par_q <= (done && frame.par_err) || (par_q && !(wr_status && !bus.wdata[ST_PAR]));
    end
  end

  // Interrupt events mirror the status layout; write one to clear, set wins.
  assign ev = {done && frame.par_err, done && frame.frm_err, done && full_q,
               done && !full_q && !frame.frm_err && !frame.par_err};
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) irq_stat_q <= '0;
    else           irq_stat_q <= ev | (irq_stat_q & ~(hit(bus, ADDR_IRQ_STAT) ? bus.wdata[3:0] : 4'h0));
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)                    irq_mask_q <= '0;
    else if (hit(bus, ADDR_IRQ_MASK)) irq_mask_q <= bus.wdata[3:0];
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // Read data registered one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_MODE:     o_rdata <= {MODE_RSVD_VAL[7:4], mode_low_q};
        ADDR_STATUS:   o_rdata <= {4'h0, par_q, frm_q, ovr_q, full_q};
        ADDR_DATA:     o_rdata <= rx_data_q;
        ADDR_IRQ_STAT: o_rdata <= {4'h0, irq_stat_q};
        ADDR_IRQ_MASK: o_rdata <= {4'h0, irq_mask_q};
        ADDR_CTRL:     o_rdata <= {4'h0, ctrl_q};
        default:       o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // no new frame accepted while an error flag stands.
  halt_on_err_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    err_any |-> !done) else $error("frame completed with error flag set");

  ovr_keep_data_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (done && full_q) |=> (ovr_q && $stable(rx_data_q))) else $error("overrun changed data");

  // framing error alone stores data and no overrun.
  frm_store_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (done && !full_q && frame.frm_err) |=> (frm_q && !ovr_q && rx_data_q == $past(frame.data)))
    else $error("framing error handling wrong");

  // errored frame leaves full flag unchanged.
  full_kept_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (done && (frame.frm_err || frame.par_err) && !wr_status) |=> (full_q == $past(full_q)))
    else $error("full flag changed on error");

  ovr_par_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (done && full_q && frame.par_err && !frame.frm_err && !frm_q) |=> (ovr_q && par_q && !frm_q))
    else $error("overrun plus parity flags wrong");

  // ratio select ignored outside async mode.
  ratio_async_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!ctrl_q[CTRL_ASYNC] || !mode_low_q[RATIO_SEL_BIT]) |-> (u_rx.ovs == 5'(OVS_16)))
    else $error("ratio select active outside async mode");

  rsvd_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (bus.rd && bus.addr == ADDR_MODE) |=> (o_rdata[7:4] == MODE_RSVD_VAL[7:4]))
    else $error("reserved bits not fixed");

  tick_period_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (tick && i_div != '0) |=> !tick) else $error("tick period wrong");
endmodule : asr_top

// file: asr_tx_model.sv
// Behavioural remote transmitter that drives serial frames onto the receive line.
`timescale 1ns/100ps
module asr_tx_model (
  input  wire logic i_clk,
  output logic      o_rxd
);
  // The line idles high between frames, as an asynchronous link must.
  initial o_rxd = 1'b1;

  // Start bit, eight data bits LSB first, even parity, stop; each held cpb clocks.
  // A false par_ok inverts the parity bit and a low stop makes a framing fault.
  task automatic send(input logic [7:0] data, input logic par_ok, input logic stop, input int cpb);
    logic [10:0] bits;
    bits = {stop, (^data) ^ ~par_ok, data, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge i_clk);
      o_rxd <= bits[i];
      repeat (cpb - 1) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_rxd <= 1'b1;
  endtask : send
endmodule : asr_tx_model

// file: asr_top_tb.sv
// Self-checking testbench for the serial receive error block.
`timescale 1ns/100ps
module asr_top_tb
  import asr_pkg::*;
;
  logic        i_clk;
  logic        i_resetn;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] i_div;
  wire logic   i_rxd;
  logic [7:0]  o_rdata;
  logic        o_irq;
  logic [7:0]  rd_val;
  int          fail_count = 0;
  int          checks_done = 0;
  // Divisor 1 gives a tick every two clocks, so 32 clocks a bit at 16x and 16 at 8x.
  localparam int BIT16 = 32;
  localparam int BIT8  = 16;

  asr_top #(.DIV_W(16)) dut (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_addr   (i_addr),
    .i_wdata  (i_wdata),
    .i_wr     (i_wr),
    .i_rd     (i_rd),
    .i_div    (i_div),
    .i_rxd    (i_rxd),
    .o_rdata  (o_rdata),
    .o_irq    (o_irq)
  );

  asr_tx_model tx (
    .i_clk (i_clk),
    .o_rxd (i_rxd)
  );

  // Free-running 20 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // One-cycle write strobe beside address and data.
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : reg_wr

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask : reg_rd

  // Compares one byte-wide result with case equality so unknowns never match.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
    reg_rd(a, rd_val);
    chk(name, exp, rd_val);
  endtask : rd_chk

  // Samples the interrupt after the last write's update has landed.
  task automatic irq_chk(input string name, input logic exp);
    #1 chk(name, {7'h00, exp}, {7'h00, o_irq});
  endtask : irq_chk

  // Sends one frame and leaves a few idle clocks for the flags to settle.
  task automatic frame(input logic [7:0] d, input logic par_ok, input logic stop, input int cpb);
    tx.send(d, par_ok, stop, cpb);
    repeat (4) @(posedge i_clk);
  endtask : frame

  // Main sequence of tests.
  initial begin
    i_resetn = 1'b0;
    i_addr   = 4'h0;
    i_wdata  = 8'h00;
    i_wr     = 1'b0;
    i_rd     = 1'b0;
    i_div    = 16'h0001;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd_chk("mode reset", ADDR_MODE, 8'h00);
    reg_wr(ADDR_MODE, 8'hFF);
    rd_chk("mode reserved", ADDR_MODE, 8'h0F);
    rd_chk("unmapped", 4'hF, 8'h00);
    reg_wr(ADDR_MODE, 8'h00);
    reg_wr(ADDR_CTRL, 8'h07);
    reg_wr(ADDR_IRQ_MASK, 8'h01);
    $display("test registers done");
    frame(8'hA5, 1'b1, 1'b1, BIT16);
    rd_chk("clean status", ADDR_STATUS, 8'h01);
    rd_chk("clean data", ADDR_DATA, 8'hA5);
    irq_chk("irq good frame", 1'b1);
    reg_wr(ADDR_IRQ_STAT, 8'h01);
    irq_chk("irq cleared", 1'b0);
    $display("test clean frame done");
    frame(8'h3C, 1'b1, 1'b1, BIT16);
    rd_chk("overrun status", ADDR_STATUS, 8'h03);
    rd_chk("overrun data", ADDR_DATA, 8'hA5);
    rd_chk("irq status", ADDR_IRQ_STAT, 8'h02);
    irq_chk("irq masked", 1'b0);
    reg_wr(ADDR_IRQ_MASK, 8'h02);
    irq_chk("irq unmasked", 1'b1);
    reg_wr(ADDR_IRQ_STAT, 8'h02);
    irq_chk("irq overrun cleared", 1'b0);
    reg_wr(ADDR_STATUS, 8'h00);
    rd_chk("flags cleared", ADDR_STATUS, 8'h00);
    $display("test overrun done");
    frame(8'h5A, 1'b1, 1'b0, BIT16);
    rd_chk("framing status", ADDR_STATUS, 8'h04);
    rd_chk("framing data", ADDR_DATA, 8'h5A);
    frame(8'h77, 1'b1, 1'b1, BIT16);
    rd_chk("halted status", ADDR_STATUS, 8'h04);
    rd_chk("halted data", ADDR_DATA, 8'h5A);
    reg_wr(ADDR_STATUS, 8'h00);
    frame(8'hC3, 1'b0, 1'b1, BIT16);
    rd_chk("parity status", ADDR_STATUS, 8'h08);
    rd_chk("parity data", ADDR_DATA, 8'hC3);
    reg_wr(ADDR_STATUS, 8'h00);
    $display("test framing and parity done");
    frame(8'h11, 1'b1, 1'b1, BIT16);
    frame(8'h22, 1'b0, 1'b1, BIT16);
    rd_chk("ovr par status", ADDR_STATUS, 8'h0B);
    rd_chk("ovr par data", ADDR_DATA, 8'h11);
    reg_wr(ADDR_STATUS, 8'h00);
    $display("test overrun with parity done");
    reg_wr(ADDR_MODE, 8'h08);
    rd_chk("mode select", ADDR_MODE, 8'h08);
    frame(8'h9E, 1'b1, 1'b1, BIT8);
    rd_chk("8x status", ADDR_STATUS, 8'h01);
    rd_chk("8x data", ADDR_DATA, 8'h9E);
    $display("test 8x ratio done");
    reg_wr(ADDR_STATUS, 8'h00);
    reg_wr(ADDR_CTRL, 8'h0F);
    frame(8'h5C, 1'b0, 1'b1, BIT8);
    rd_chk("odd parity status", ADDR_STATUS, 8'h01);
    rd_chk("odd parity data", ADDR_DATA, 8'h5C);
    reg_wr(ADDR_STATUS, 8'h00);
    reg_wr(ADDR_CTRL, 8'h03);
    frame(8'h01, 1'b1, 1'b1, BIT8);
    rd_chk("no parity status", ADDR_STATUS, 8'h01);
    rd_chk("no parity data", ADDR_DATA, 8'h01);
    $display("test parity modes done");
    give_verdict();
  end

  // Watchdog: the tests need about 3100 clocks, so 30000 means a hang.
  initial begin
    #(30000 * 50);
    fail_count++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule : asr_top_tb
